// file: design/sbp_basic_param_rom_mid.sv
`timescale 1ns/10ps
// Overview of operation
// - parameter opens with identifier then length byte
// - offset 0Ch returns 08h dual-out cycles
// - offset 0Dh returns 3Bh dual-out opcode
// - offset 0Eh returns 80h dual-io cycles
// - offset 0Fh returns BBh dual-io opcode
// - offset 10h returns EEh all-modes flags
// - reserved bytes return FFh
// - offset 16h returns FFh dual-all cycles
// - offset 17h returns FFh dual-all opcode
// - offset 1Ah returns FFh quad-all cycles
// - offset 1Bh returns FFh quad-all opcode
// - offset 1Dh returns 20h erase-one opcode
// - offset 1Fh returns D8h erase-two opcode
// - offset 21h returns D8h erase-three opcode
// - offset 23h returns FFh erase-four opcode
module sbp_basic_param_rom_mid
	import sbp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       start,
	input  wire logic [7:0] start_ofs,
	input  wire logic       hdr_sel,
	input  wire logic       next_req,
	input  wire logic       stop,
	output logic            busy,
	output logic            valid,
	output logic [7:0]      rd_data,
	output logic            in_range,
	output logic [7:0]      cur_ofs
);

	// ************************************************************
	// sequencer state
	// ************************************************************
	sbp_state_type state;
	sbp_state_type next_state;
	logic [7:0]    ofs;
	logic [7:0]    next_ofs;
	logic          hdr_mode;
	logic          next_hdr_mode;
	logic          fetch;
	logic          fetch_q;
	logic          next_fetch_q;
	logic          hdr_q;
	logic          next_hdr_q;

	sbp_rd_if      rd ();
	logic [7:0]    hdr_data;

	// one byte fetched per start or next_req while a burst is open
	always_comb
	begin
		next_state    = state;
		next_ofs      = ofs;
		next_hdr_mode = hdr_mode;
		fetch         = 1'b0;
		case (state)
			SBP_IDLE:
			begin
				if (start)
				begin
					next_state    = SBP_BURST;
					next_ofs      = start_ofs;
					next_hdr_mode = hdr_sel;
					fetch         = 1'b1;
				end
			end
			SBP_BURST:
			begin
				if (stop)
					next_state = SBP_IDLE;
				else if (next_req)
				begin
					// address wraps at 8 bits; a host never walks that far
					next_ofs = ofs + 8'h01;
					fetch    = 1'b1;
				end
			end
			default:
				next_state = SBP_IDLE;
		endcase
		next_fetch_q = fetch;
		next_hdr_q   = fetch ? next_hdr_mode : hdr_q;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state    <= SBP_IDLE;
			ofs      <= 8'h00;
			hdr_mode <= 1'b0;
			fetch_q  <= 1'b0;
			hdr_q    <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			ofs      <= next_ofs;
			hdr_mode <= next_hdr_mode;
			fetch_q  <= next_fetch_q;
			hdr_q    <= next_hdr_q;
		end
	end

	// ************************************************************
	// lookups
	// ************************************************************
	// both lookups see the address of the byte being fetched now
	assign rd.en   = fetch && !next_hdr_mode;
	assign rd.addr = next_ofs;

	sbp_table_rom u_table (
		.clk    (clk),
		.arst_n (arst_n),
		.rd     (rd.rom)
	);

	sbp_hdr_rom u_hdr (
		.clk     (clk),
		.arst_n  (arst_n),
		.en      (fetch && next_hdr_mode),
		.sel_len (next_ofs[0]),
		.data    (hdr_data)
	);

	// ************************************************************
	// outputs
	// ************************************************************
	// header path always counts as in range for its two bytes
	assign busy     = (state == SBP_BURST);
	assign valid    = fetch_q;
	assign rd_data  = hdr_q ? hdr_data : rd.data;
	assign in_range = hdr_q ? 1'b1 : rd.hit;
	assign cur_ofs  = ofs;

endmodule : sbp_basic_param_rom_mid

// file: design/sbp_hdr_rom.sv
`timescale 1ns/10ps
// registered two-byte parameter header
module sbp_hdr_rom
	import sbp_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic en,
	input  wire logic sel_len,
	output logic [7:0] data
);

	logic [7:0] next_data;

	// header: identifier first, then length of what follows
	always_comb
	begin
		next_data = data;
		if (en)
			next_data = sel_len ? HDR_LENGTH_VALUE : HDR_ID_VALUE;
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			data <= HDR_ID_VALUE;
		else
			data <= next_data;
	end

endmodule : sbp_hdr_rom

// file: design/sbp_table_rom.sv
`timescale 1ns/10ps
// registered constant lookup of one table byte
module sbp_table_rom
	import sbp_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	sbp_rd_if.rom     rd
);

	logic [7:0] data;
	logic [7:0] next_data;
	logic       hit;
	logic       next_hit;

	// ************************************************************
	// constant contents
	// ************************************************************
	function automatic logic [7:0] table_byte(input logic [7:0] ofs);
		logic [7:0] b;
		b = VAL_OUT_OF_RANGE;
		case (ofs)
			OFS_DUAL_OUT_CYC: b = VAL_DUAL_OUT_CYC;
			OFS_DUAL_OUT_OP:  b = VAL_DUAL_OUT_OP;
			OFS_DUAL_IO_CYC:  b = VAL_DUAL_IO_CYC;
			OFS_DUAL_IO_OP:   b = VAL_DUAL_IO_OP;
			OFS_ALL_MODES:    b = VAL_ALL_MODES;
			OFS_DUAL_ALL_CYC: b = VAL_ABSENT_CYC;
			OFS_DUAL_ALL_OP:  b = VAL_ABSENT_OP;
			OFS_QUAD_ALL_CYC: b = VAL_ABSENT_CYC;
			OFS_QUAD_ALL_OP:  b = VAL_ABSENT_OP;
			OFS_ERASE1_SIZE:  b = VAL_ERASE1_SIZE;
			OFS_ERASE1_OP:    b = VAL_ERASE1_OP;
			OFS_ERASE2_SIZE:  b = VAL_ERASE2_SIZE;
			OFS_ERASE2_OP:    b = VAL_ERASE2_OP;
			OFS_ERASE3_SIZE:  b = VAL_ERASE3_SIZE;
			OFS_ERASE3_OP:    b = VAL_ERASE3_OP;
			OFS_ERASE4_SIZE:  b = VAL_ERASE4_SIZE;
			OFS_ERASE4_OP:    b = VAL_ERASE4_OP;
			// reserved_field bytes 11h-15h, 18h, 19h
			default:
			begin
				if (ofs >= OFS_FIRST && ofs <= OFS_LAST)
					b = VAL_RESERVED;
			end
		endcase
		return b;
	endfunction : table_byte

	// next values: hold last byte when not enabled
	always_comb
	begin
		next_data = data;
		next_hit  = hit;
		if (rd.en)
		begin
			next_data = table_byte(rd.addr);
			next_hit  = (rd.addr >= OFS_FIRST) && (rd.addr <= OFS_LAST);
		end
	end

	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			data <= VAL_OUT_OF_RANGE;
			hit  <= 1'b0;
		end
		else
		begin
			data <= next_data;
			hit  <= next_hit;
		end
	end

	assign rd.data = data;
	assign rd.hit  = hit;

endmodule : sbp_table_rom

// file: shared/sbp_pkg.sv
package sbp_pkg;

	// ************************************************************
	// table geometry
	// ************************************************************
	localparam int unsigned ADDR_WIDTH = 8;
	localparam int unsigned DATA_WIDTH = 8;

	// discovery-table parameter header bytes
	localparam logic [7:0] HDR_ID_VALUE     = 8'ha5;
	localparam logic [7:0] HDR_LENGTH_VALUE = 8'h80;

	// first and last relative offset held by this block
	localparam logic [7:0] OFS_FIRST = 8'h0c;
	localparam logic [7:0] OFS_LAST  = 8'h23;

	// ************************************************************
	// relative offsets
	// ************************************************************
	localparam logic [7:0] OFS_DUAL_OUT_CYC  = 8'h0c;
	localparam logic [7:0] OFS_DUAL_OUT_OP   = 8'h0d;
	localparam logic [7:0] OFS_DUAL_IO_CYC   = 8'h0e;
	localparam logic [7:0] OFS_DUAL_IO_OP    = 8'h0f;
	localparam logic [7:0] OFS_ALL_MODES     = 8'h10;
	localparam logic [7:0] OFS_DUAL_ALL_CYC  = 8'h16;
	localparam logic [7:0] OFS_DUAL_ALL_OP   = 8'h17;
	localparam logic [7:0] OFS_QUAD_ALL_CYC  = 8'h1a;
	localparam logic [7:0] OFS_QUAD_ALL_OP   = 8'h1b;
	localparam logic [7:0] OFS_ERASE1_SIZE   = 8'h1c;
	localparam logic [7:0] OFS_ERASE1_OP     = 8'h1d;
	localparam logic [7:0] OFS_ERASE2_SIZE   = 8'h1e;
	localparam logic [7:0] OFS_ERASE2_OP     = 8'h1f;
	localparam logic [7:0] OFS_ERASE3_SIZE   = 8'h20;
	localparam logic [7:0] OFS_ERASE3_OP     = 8'h21;
	localparam logic [7:0] OFS_ERASE4_SIZE   = 8'h22;
	localparam logic [7:0] OFS_ERASE4_OP     = 8'h23;

	// ************************************************************
	// byte values
	// ************************************************************
	localparam logic [7:0] VAL_DUAL_OUT_CYC  = 8'h08;
	localparam logic [7:0] VAL_DUAL_OUT_OP   = 8'h3b;
	localparam logic [7:0] VAL_DUAL_IO_CYC   = 8'h80;
	localparam logic [7:0] VAL_DUAL_IO_OP    = 8'hbb;
	localparam logic [7:0] VAL_ALL_MODES     = 8'hee;
	localparam logic [7:0] VAL_RESERVED      = 8'hff;
	localparam logic [7:0] VAL_ABSENT_CYC    = 8'hff;
	localparam logic [7:0] VAL_ABSENT_OP     = 8'hff;
	localparam logic [7:0] VAL_ERASE1_SIZE   = 8'h0c;
	localparam logic [7:0] VAL_ERASE1_OP     = 8'h20;
	localparam logic [7:0] VAL_ERASE2_SIZE   = 8'h10;
	localparam logic [7:0] VAL_ERASE2_OP     = 8'hd8;
	localparam logic [7:0] VAL_ERASE3_SIZE   = 8'h12;
	localparam logic [7:0] VAL_ERASE3_OP     = 8'hd8;
	localparam logic [7:0] VAL_ERASE4_SIZE   = 8'h00;
	localparam logic [7:0] VAL_ERASE4_OP     = 8'hff;

	// answer outside the held range
	localparam logic [7:0] VAL_OUT_OF_RANGE  = 8'hff;

	// ************************************************************
	// sequencer
	// ************************************************************
	typedef enum logic [0:0] {
		SBP_IDLE  = 1'b0,
		SBP_BURST = 1'b1
	} sbp_state_type;

endpackage : sbp_pkg

// file: shared/sbp_rd_if.sv
`timescale 1ns/10ps
// ************************************************************
// byte lookup path between sequencer and table
// ************************************************************
interface sbp_rd_if;
	logic       en;
	logic [7:0] addr;
	logic [7:0] data;
	logic       hit;

	modport seq (output en, output addr, input data, input hit);
	modport rom (input en, input addr, output data, output hit);
endinterface : sbp_rd_if

// file: tb/sbp_basic_param_rom_mid_monitor.sv
`timescale 1ns/10ps
// ************************************************************
// port checker
// ************************************************************
module sbp_basic_param_rom_mid_monitor
	import sbp_pkg::*;
(
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic       start,
	input wire logic [7:0] start_ofs,
	input wire logic       hdr_sel,
	input wire logic       next_req,
	input wire logic       stop,
	input wire logic       busy,
	input wire logic       valid,
	input wire logic [7:0] rd_data,
	input wire logic       in_range,
	input wire logic [7:0] cur_ofs
);
	logic hdr_burst;
	logic tbl_valid;

	default clocking
		@(posedge clk);
	endclocking
	default disable iff (!arst_n);

	// header bursts reuse cur_ofs as byte select, so table checks must skip them
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			hdr_burst <= 1'b0;
		else if (!busy && start)
			hdr_burst <= hdr_sel;
	end

	// a table byte is on the output lines
	assign tbl_valid = valid && !hdr_burst;

	// handshake timing: answers one cycle after the taking edge
	first_fetch_a : assert property (!busy && start |=> valid && busy)
		else $error("start not answered");
	first_ofs_a : assert property (!busy && start && !hdr_sel |=> cur_ofs == $past(start_ofs))
		else $error("wrong first offset");
	step_ofs_a : assert property (busy && next_req && !stop |=> valid && cur_ofs == $past(cur_ofs) + 8'h01)
		else $error("offset did not step");
	stop_end_a : assert property (busy && stop |=> !busy && !valid)
		else $error("stop ignored");
	idle_quiet_a : assert property (!busy && !start |=> !valid)
		else $error("byte without request");
	// table contents at offsets that carry meaning
	dual_out_a : assert property (tbl_valid && cur_ofs == 8'h0c |-> rd_data == 8'h08)
		else $error("bad dual-out cycles");
	dual_op_a : assert property (tbl_valid && cur_ofs == 8'h0d |-> rd_data == 8'h3b)
		else $error("bad dual-out opcode");
	dual_io_a : assert property (tbl_valid && cur_ofs == 8'h0e |-> rd_data == 8'h80)
		else $error("bad dual-io cycles");
	mode_flags_a : assert property (tbl_valid && cur_ofs == 8'h10 |-> rd_data == 8'hee)
		else $error("bad mode flags");
	absent_modes_a : assert property (tbl_valid && cur_ofs inside {[8'h11:8'h1b]}
		|-> rd_data == 8'hff)
		else $error("reserved byte not ones");
	erase_one_a : assert property (tbl_valid && cur_ofs == 8'h1c |-> rd_data == 8'h0c)
		else $error("bad erase-one size");
	erase_four_a : assert property (tbl_valid && cur_ofs == 8'h22 |-> rd_data == 8'h00)
		else $error("bad erase-four size");
	// header bytes: identifier on an even select, length on an odd one
	hdr_bytes_a : assert property (valid && hdr_burst
		|-> rd_data == (cur_ofs[0] ? 8'h80 : 8'ha5))
		else $error("bad header byte");
endmodule : sbp_basic_param_rom_mid_monitor

bind sbp_basic_param_rom_mid sbp_basic_param_rom_mid_monitor mon (.clk(clk), .arst_n(arst_n),
	.start(start), .start_ofs(start_ofs), .hdr_sel(hdr_sel), .next_req(next_req), .stop(stop),
	.busy(busy), .valid(valid), .rd_data(rd_data), .in_range(in_range), .cur_ofs(cur_ofs));

// file: tb/sbp_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// host reading the discovery table
// ************************************************************
module sbp_host_model
(
	input  wire logic       clk,
	input  wire logic       valid,
	input  wire logic [7:0] rd_data,
	input  wire logic       in_range,
	output logic            start,
	output logic [7:0]      start_ofs,
	output logic            hdr_sel,
	output logic            next_req,
	output logic            stop
);
	logic [7:0] got[$];
	logic       rng[$];

	// quiet lines at time zero
	initial
	begin
		start = 1'b0;
		start_ofs = 8'h00;
		hdr_sel = 1'b0;
		next_req = 1'b0;
		stop = 1'b0;
	end

	// valid stands one cycle, so every answer is queued at that edge
	always @(posedge clk)
	begin
		if (valid === 1'b1)
		begin
			got.push_back(rd_data);
			rng.push_back(in_range);
		end
	end

	// gap 0 keeps next_req high beside stop, which must win
	task automatic burst(input logic [7:0] ofs, input int n, input logic hdr, input int gap);
		@(posedge clk);
		#1;
		start = 1'b1;
		start_ofs = ofs;
		hdr_sel = hdr;
		@(posedge clk);
		#1;
		start = 1'b0;
		start_ofs = ~ofs; // released offset lines do not keep the old value
		hdr_sel = 1'b0;
		for (int i = 1; i < n; i++)
		begin
			next_req = 1'b1;
			@(posedge clk);
			#1;
			if (gap > 0)
			begin
				next_req = 1'b0;
				repeat (gap) @(posedge clk);
				#1;
			end
		end
		stop = 1'b1;
		@(posedge clk);
		#1;
		stop = 1'b0;
		next_req = 1'b0;
	endtask : burst
endmodule : sbp_host_model

// file: tb/tb.sv
`timescale 1ns/10ps
// ************************************************************
// bench top
// ************************************************************
module tb
	import sbp_pkg::*;
;
	logic       clk;
	logic       arst_n;
	logic       start;
	logic [7:0] start_ofs;
	logic       hdr_sel;
	logic       next_req;
	logic       stop;
	logic       valid;
	logic [7:0] rd_data;
	logic       in_range;
	int         errors;
	int         samples_checked;
	int         cycles;

	sbp_basic_param_rom_mid dut (.clk(clk), .arst_n(arst_n), .start(start),
		.start_ofs(start_ofs), .hdr_sel(hdr_sel), .next_req(next_req), .stop(stop),
		.busy(), .valid(valid), .rd_data(rd_data), .in_range(in_range), .cur_ofs());
	sbp_host_model host (.clk(clk), .valid(valid), .rd_data(rd_data), .in_range(in_range),
		.start(start), .start_ofs(start_ofs), .hdr_sel(hdr_sel), .next_req(next_req), .stop(stop));

	// clock and a hang guard well above the fewer than a hundred cycles needed
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			report_and_stop();
		end
	end

	function automatic logic [7:0] exp_byte(input logic [7:0] o);
		case (o)
			8'h0c: exp_byte = 8'h08;
			8'h0d: exp_byte = 8'h3b;
			8'h0e: exp_byte = 8'h80;
			8'h0f: exp_byte = 8'hbb;
			8'h10: exp_byte = 8'hee;
			8'h1c: exp_byte = 8'h0c;
			8'h1d: exp_byte = 8'h20;
			8'h1e: exp_byte = 8'h10;
			8'h1f: exp_byte = 8'hd8;
			8'h20: exp_byte = 8'h12;
			8'h21: exp_byte = 8'hd8;
			8'h22: exp_byte = 8'h00;
			// reserved, absent modes, erase-four opcode and beyond the table
			default: exp_byte = 8'hff;
		endcase
	endfunction : exp_byte

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			errors++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, want);
		end
	endtask : chk

	// one burst, then byte count, data and range flag per offset
	task automatic run(input logic [7:0] ofs, input int n, input int gap);
		logic [7:0] o;
		host.got.delete();
		host.rng.delete();
		host.burst(ofs, n, 1'b0, gap);
		chk(8'(host.got.size()), 8'(n));
		for (int i = 0; i < host.got.size(); i++)
		begin
			o = ofs + 8'(i);
			chk(host.got[i], exp_byte(o));
			chk({7'h00, host.rng[i]}, {7'h00, o >= 8'h0c && o <= 8'h23});
		end
	endtask : run

	task automatic t_whole_table;
		run(8'h0c, 24, 0);
	endtask : t_whole_table

	task automatic t_slow_erase;
		run(8'h1c, 8, 2);
	endtask : t_slow_erase

	task automatic t_past_end;
		run(8'h22, 4, 0);
	endtask : t_past_end

	task automatic t_header;
		host.got.delete();
		host.rng.delete();
		host.burst(8'h00, 2, 1'b1, 1);
		chk(8'(host.got.size()), 8'h02);
		chk(host.got[0], 8'ha5);
		chk(host.got[1], 8'h80);
		chk({7'h00, host.rng[0]}, 8'h01);
		chk({7'h00, host.rng[1]}, 8'h01);
	endtask : t_header

	task automatic report_and_stop;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	initial
	begin
		arst_n = 1'b0;
		repeat (5) @(posedge clk);
		#1;
		arst_n = 1'b1;
		t_whole_table();
		t_slow_erase();
		t_header();
		t_past_end();
		report_and_stop();
	end
endmodule : tb
